/* hdl/arsel_input_decode.sv */
/*
  Combinational decode of input source and channel codes into analog switch
  enables. Assumes next-value codes at its inputs, with flops behind its outputs.
*/
`timescale 1ns/10ps
module arsel_input_decode (
  // Codes.
  input wire logic [3:0] src_i,
  input wire logic [3:0] chan_i,
  // Decoded selects.
  output logic ext_mode_o,
  output logic [8:0] ain_en_o,
  output logic [1:0] div_o,
  output logic int_supply_o,
  output logic int_amp_o,
  output logic int_gnd_o
);
  import arsel_pkg::*;

  // ==========================================================================
  // Source class.
  wire logic is_ext;
  assign is_ext = (src_i == 4'h0) || (src_i == 4'h4) || (src_i[3:2] == 2'h3);
  assign ext_mode_o = is_ext;
  assign int_supply_o = (src_i[3:2] == 2'h0) && (src_i[1:0] != 2'h0);
  assign int_amp_o = (src_i[3:2] == 2'h1) && (src_i[1:0] != 2'h0);
  assign int_gnd_o = (src_i[3:2] == 2'h2);
  // Divider: 1 = full, 2 = half, 3 = quarter.
  assign div_o = (int_supply_o || int_amp_o) ? src_i[1:0] : 2'h0;

  // ==========================================================================
  // One-hot channel, only in external mode; internal forces all off.
  wire logic chan_ok;
  assign chan_ok = (chan_i != 4'h2) && (chan_i <= 4'h8);
  assign ain_en_o = (is_ext && chan_ok) ? (9'h001 << chan_i) : 9'h000;
endmodule

/* hdl/arsel_pkg.sv */
/*
  Package for the converter reference and input select block: register offsets,
  field positions, reset values and select encodings.
  Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
// ==========================================================================
package arsel_pkg;
  // ========================================================================
  // Register map (byte addresses).
  localparam logic [3:0] OFS_REF_AMP_CTRL = 4'h0;
  localparam logic [3:0] OFS_BANDGAP_CTRL = 4'h4;
  localparam logic [3:0] OFS_INPUT_SEL = 4'h8;
  localparam logic [3:0] OFS_PIN_ANALOG = 4'hC;
  // Field positions in the reference and bandgap control registers.
  localparam int AMP_EN_BIT = 7;
  localparam int AMP_SRC_BIT = 4;
  localparam int REF_SEL_LSB = 2;
  localparam int GAIN_LSB = 0;
  localparam int BG_EN_BIT = 0;
  // Field positions in the input select register.
  localparam int CHAN_LSB = 0;
  localparam int SRC_LSB = 4;
  // Reset values.
  localparam logic [7:0] RST_REF_AMP = 8'h00;
  localparam logic [7:0] RST_BANDGAP = 8'h00;
  localparam logic [7:0] RST_INPUT = 8'h00;
  // Implemented-bit masks.
  localparam logic [7:0] MASK_REF_AMP = 8'h9F;
  localparam logic [7:0] MASK_BANDGAP = 8'h01;
  // Converter input kinds.
  typedef enum logic [2:0] {
    ARS_IN_EXT, ARS_IN_SUPPLY, ARS_IN_AMP, ARS_IN_GND
  } ars_in_kind_t;
  // Reference source kinds.
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_AMP = 2'h2;
  // Number of external analog inputs.
  localparam int NUM_AIN = 9;
endpackage

/* hdl/arsel_top.sv */
/*
  Converter reference and input select block with Avalon-MM register access.
  Assumes a synchronous active-low reset and one 200 MHz system clock.
*/
`timescale 1ns/10ps
module arsel_top #(
  parameter int PIN_COUNT = arsel_pkg::NUM_AIN
) (
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // Avalon-MM slave.
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [1:0] AVS_RESPONSE_O,
  // Amplifier and bandgap controls.
  output logic AMP_ENABLE_O,
  output logic AMP_SRC_BANDGAP_O,
  output logic AMP_REF_PIN_CONNECT_O,
  output logic [1:0] AMP_GAIN_SEL_O,
  output logic BANDGAP_ENABLE_O,
  // Converter reference selects.
  output logic REF_SEL_SUPPLY_O,
  output logic REF_SEL_PIN_O,
  output logic REF_SEL_AMP_O,
  // Converter input selects.
  output logic [8:0] AIN_CONNECT_O,
  output logic INT_SUPPLY_O,
  output logic INT_AMP_O,
  output logic INT_GND_O,
  output logic [1:0] INT_DIV_O,
  // Pin overrides for analog-assigned pins.
  output logic [8:0] PIN_FUNC_DISABLE_O,
  output logic [8:0] PIN_PULLUP_OFF_O,
  output logic [8:0] PIN_DIR_FORCE_IN_O
);
  import arsel_pkg::*;

  // Elaboration check: the switch vectors are sized for the analog input count.
  if (PIN_COUNT != NUM_AIN) begin : g_bad_pin_count
    $error("PIN_COUNT must equal the analog input count");
  end

  // ==========================================================================
  // Registers.
  logic [7:0] ref_amp_r;
  logic [7:0] bandgap_r;
  logic [7:0] input_sel_r;
  logic [8:0] pin_analog_r;
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [1:0] resp_r;

  // Bus decode.
  wire logic req;
  wire logic wr_go;
  wire logic rd_go;
  wire logic hit_ref;
  wire logic hit_bg;
  wire logic hit_in;
  wire logic hit_pin;
  wire logic hit_any;
  assign req = (AVS_READ_I || AVS_WRITE_I) && !ack_r;
  assign wr_go = AVS_WRITE_I && !ack_r;
  assign rd_go = AVS_READ_I && !ack_r;
  assign hit_ref = (AVS_ADDRESS_I == OFS_REF_AMP_CTRL);
  assign hit_bg = (AVS_ADDRESS_I == OFS_BANDGAP_CTRL);
  assign hit_in = (AVS_ADDRESS_I == OFS_INPUT_SEL);
  assign hit_pin = (AVS_ADDRESS_I == OFS_PIN_ANALOG);
  assign hit_any = hit_ref || hit_bg || hit_in || hit_pin;

  // Read mux; unimplemented bits read zero.
  wire logic [31:0] rd_mux;
  assign rd_mux = hit_ref ? {24'h000000, ref_amp_r} :
                  hit_bg ? {24'h000000, bandgap_r} :
                  hit_in ? {24'h000000, input_sel_r} :
                  hit_pin ? {23'h0, pin_analog_r} : 32'h00000000;

  // Next values of writable registers, low byte lane; the pin register needs lanes 0 and 1.
  wire logic lane0;
  wire logic [7:0] ref_amp_nxt;
  wire logic [7:0] bandgap_nxt;
  wire logic [7:0] input_sel_nxt;
  wire logic [8:0] pin_analog_nxt;
  assign lane0 = wr_go && AVS_BYTEENABLE_I[0];
  assign ref_amp_nxt = (lane0 && hit_ref) ? (AVS_WRITEDATA_I[7:0] & MASK_REF_AMP) : ref_amp_r;
  assign bandgap_nxt = (lane0 && hit_bg) ? (AVS_WRITEDATA_I[7:0] & MASK_BANDGAP)
                     : bandgap_r;
  assign input_sel_nxt = (lane0 && hit_in) ? AVS_WRITEDATA_I[7:0] : input_sel_r;
  assign pin_analog_nxt = (wr_go && hit_pin && AVS_BYTEENABLE_I[1:0] == 2'h3)
                        ? AVS_WRITEDATA_I[8:0] : pin_analog_r;

  // Register update and one-wait-state answer.
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ref_amp_r <= RST_REF_AMP;
      bandgap_r <= RST_BANDGAP;
      input_sel_r <= RST_INPUT;
      pin_analog_r <= 9'h000;
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      resp_r <= 2'h0;
    end else begin
      ref_amp_r <= ref_amp_nxt;
      bandgap_r <= bandgap_nxt;
      input_sel_r <= input_sel_nxt;
      pin_analog_r <= pin_analog_nxt;
      ack_r <= req;
      wait_r <= !req;
      if (rd_go) begin
        rdata_r <= rd_mux;
      end
      if (req) begin
        resp_r <= hit_any ? 2'h0 : 2'h2; // Unmapped answers SLVERR.
      end
    end
  end

  // Waitrequest is high until the cycle after the request is taken.
  assign AVS_WAITREQUEST_O = wait_r;
  assign AVS_READDATA_O = rdata_r;
  assign AVS_RESPONSE_O = resp_r;

  // ==========================================================================
  // Decode of control fields. Register values due at the coming edge, reset
  // included, feed the output flops, so a pin changes at the very edge at
  // which its register does and never lags it by a cycle.
  wire logic [7:0] ref_amp_d;
  wire logic [7:0] input_sel_d;
  wire logic [8:0] pin_analog_d;
  assign ref_amp_d = NRST_I ? ref_amp_nxt : RST_REF_AMP;
  assign input_sel_d = NRST_I ? input_sel_nxt : RST_INPUT;
  assign pin_analog_d = NRST_I ? pin_analog_nxt : 9'h000;

  // Plain register bits leave the block as they stand in their flops.
  assign AMP_ENABLE_O = ref_amp_r[AMP_EN_BIT];
  assign AMP_SRC_BANDGAP_O = ref_amp_r[AMP_SRC_BIT];
  assign AMP_GAIN_SEL_O = ref_amp_r[GAIN_LSB +: 2];
  assign BANDGAP_ENABLE_O = bandgap_r[BG_EN_BIT];

  // Reference and amplifier input paths.
  wire logic [1:0] ref_sel;
  wire logic amp_pin_on;
  wire logic ref_supply_sel;
  wire logic ref_pin_sel;
  wire logic ref_amp_sel;
  assign ref_sel = ref_amp_d[REF_SEL_LSB +: 2];
  assign amp_pin_on = !ref_amp_d[AMP_SRC_BIT];
  assign ref_supply_sel = (ref_sel == REF_SUPPLY);
  assign ref_pin_sel = (ref_sel == REF_PIN);
  assign ref_amp_sel = ref_sel[1];

  // Input select decode.
  wire logic [8:0] ain_en;
  wire logic [1:0] int_div;
  wire logic int_supply;
  wire logic int_amp;
  wire logic int_gnd;
  wire logic [8:0] ain_conn;
  arsel_input_decode u_dec (
    .src_i(input_sel_d[SRC_LSB +: 4]),
    .chan_i(input_sel_d[CHAN_LSB +: 4]),
    .ext_mode_o(),
    .ain_en_o(ain_en),
    .div_o(int_div),
    .int_supply_o(int_supply),
    .int_amp_o(int_amp),
    .int_gnd_o(int_gnd)
  );
  // A channel switch also needs its pin assigned analog, so a pin that still
  // serves a digital function is never tied to the converter.
  assign ain_conn = ain_en & pin_analog_d;

  // Flops behind the decoded outputs; their inputs already carry reset.
  logic amp_pin_on_r;
  logic ref_supply_r;
  logic ref_pin_r;
  logic ref_amp_sel_r;
  logic [8:0] ain_conn_r;
  logic int_supply_r;
  logic int_amp_r;
  logic int_gnd_r;
  logic [1:0] int_div_r;
  always_ff @(posedge CLK_SYS_I) begin
    amp_pin_on_r <= amp_pin_on;
    ref_supply_r <= ref_supply_sel;
    ref_pin_r <= ref_pin_sel;
    ref_amp_sel_r <= ref_amp_sel;
    ain_conn_r <= ain_conn;
    int_supply_r <= int_supply;
    int_amp_r <= int_amp;
    int_gnd_r <= int_gnd;
    int_div_r <= int_div;
  end

  // Decoded outputs straight from their flops.
  assign AMP_REF_PIN_CONNECT_O = amp_pin_on_r;
  assign REF_SEL_SUPPLY_O = ref_supply_r;
  assign REF_SEL_PIN_O = ref_pin_r;
  assign REF_SEL_AMP_O = ref_amp_sel_r;
  assign AIN_CONNECT_O = ain_conn_r;
  assign INT_SUPPLY_O = int_supply_r;
  assign INT_AMP_O = int_amp_r;
  assign INT_GND_O = int_gnd_r;
  assign INT_DIV_O = int_div_r;

  // Analog-assigned pins lose other functions, pull-high and direction.
  assign PIN_FUNC_DISABLE_O = pin_analog_r;
  assign PIN_PULLUP_OFF_O = pin_analog_r;
  assign PIN_DIR_FORCE_IN_O = pin_analog_r;

  // ==========================================================================
  // Checks.
  property p_amp_pin_off;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      AMP_SRC_BANDGAP_O |-> !AMP_REF_PIN_CONNECT_O;
  endproperty
  a_amp_pin_off: assert property (p_amp_pin_off) else $error("amp pin path on");

  property p_ref_pin_off;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (REF_SEL_SUPPLY_O || REF_SEL_AMP_O) |-> !REF_SEL_PIN_O;
  endproperty
  a_ref_pin_off: assert property (p_ref_pin_off) else $error("ref pin path on");

  property p_ref_onehot;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      $onehot({REF_SEL_SUPPLY_O, REF_SEL_PIN_O, REF_SEL_AMP_O});
  endproperty
  a_ref_onehot: assert property (p_ref_onehot) else $error("ref select not onehot");

  property p_int_no_ext;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (INT_SUPPLY_O || INT_AMP_O || INT_GND_O) |-> (AIN_CONNECT_O == 9'h000);
  endproperty
  a_int_no_ext: assert property (p_int_no_ext) else $error("ext channel on");

  property p_ain_onehot;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      $onehot0(AIN_CONNECT_O) && !AIN_CONNECT_O[2];
  endproperty
  a_ain_onehot: assert property (p_ain_onehot) else $error("bad channel");

  property p_bg_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (wr_go && hit_bg && AVS_BYTEENABLE_I[0])
        |=> (bandgap_r == {7'h00, $past(AVS_WRITEDATA_I[0])});
  endproperty
  a_bg_write: assert property (p_bg_write) else $error("bandgap write");

  property p_amp_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (wr_go && hit_ref && AVS_BYTEENABLE_I[0])
        |=> (AMP_ENABLE_O == $past(AVS_WRITEDATA_I[7]))
            && (AMP_GAIN_SEL_O == $past(AVS_WRITEDATA_I[1:0]));
  endproperty
  a_amp_write: assert property (p_amp_write) else $error("ref write");

  property p_reset;
    @(posedge CLK_SYS_I) !NRST_I |=> (ref_amp_r == 8'h00) && (input_sel_r == 8'h00);
  endproperty
  a_reset: assert property (p_reset) else $error("reset value");

  property p_wait_one;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (req) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing");

  // A reference write sets the one-hot reference select from bits 3:2.
  property p_ref_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (wr_go && hit_ref && AVS_BYTEENABLE_I[0])
        |=> (REF_SEL_AMP_O == $past(AVS_WRITEDATA_I[3]))
            && (REF_SEL_PIN_O == ($past(AVS_WRITEDATA_I[3:2]) == REF_PIN));
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("ref select write");

  // The amplifier pin path is on exactly when the bandgap is not chosen.
  property p_src_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (wr_go && hit_ref && AVS_BYTEENABLE_I[0])
        |=> (AMP_REF_PIN_CONNECT_O == !$past(AVS_WRITEDATA_I[4]))
            && (AMP_SRC_BANDGAP_O == $past(AVS_WRITEDATA_I[4]));
  endproperty
  a_src_write: assert property (p_src_write) else $error("amp source write");

  // Unimplemented bandgap control bits read back as zero.
  property p_bg_read;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (rd_go && hit_bg) |=> (AVS_READDATA_O[31:1] == 31'h0);
  endproperty
  a_bg_read: assert property (p_bg_read) else $error("bandgap upper bits");

  // Ground is chosen alone and without a divider.
  property p_gnd_only;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      INT_GND_O |-> !INT_SUPPLY_O && !INT_AMP_O && (INT_DIV_O == 2'h0);
  endproperty
  a_gnd_only: assert property (p_gnd_only) else $error("ground select");

  // Supply and amplifier fractions always name a divider.
  property p_int_div;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (INT_SUPPLY_O || INT_AMP_O) |-> (INT_DIV_O != 2'h0);
  endproperty
  a_int_div: assert property (p_int_div) else $error("divider select");

  // Only pins assigned analog are ever switched to the converter.
  property p_ain_assigned;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (AIN_CONNECT_O & ~PIN_FUNC_DISABLE_O) == 9'h000;
  endproperty
  a_ain_assigned: assert property (p_ain_assigned) else $error("pin not analog");

  // An external source code with channel 8 routes that pin if it is analog.
  property p_in_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (wr_go && hit_in && AVS_BYTEENABLE_I[0] && (AVS_WRITEDATA_I[7:6] == 2'h3)
        && (AVS_WRITEDATA_I[3:0] == 4'h8)) |=> (AIN_CONNECT_O[8] == pin_analog_r[8]);
  endproperty
  a_in_write: assert property (p_in_write) else $error("external route");

  c_int_amp: cover property (@(posedge CLK_SYS_I) INT_AMP_O && INT_DIV_O == 2'h3);
  c_ext_ch8: cover property (@(posedge CLK_SYS_I) AIN_CONNECT_O[8]);
  c_ref_amp: cover property (@(posedge CLK_SYS_I) REF_SEL_AMP_O && AMP_SRC_BANDGAP_O);
  c_int_gnd: cover property (@(posedge CLK_SYS_I) INT_GND_O);
  c_ref_pin: cover property (@(posedge CLK_SYS_I) REF_SEL_PIN_O && AMP_REF_PIN_CONNECT_O);
endmodule

/* tb/arsel_analog_model.sv */
/*
  Far-side analog model: the switch network that the select lines drive.
  Assumes the select outputs of the block wired in, the internal ones ORed per node.
*/
`timescale 1ns/10ps
module arsel_analog_model (
  // Select lines from the block.
  input wire logic [8:0] ain_i,
  input wire logic int_i,
  input wire logic ref_pin_i,
  input wire logic ref_int_i,
  // Fault flag.
  output logic short_o
);
  // ==========================================================================
  // Short detection
  // A pin tied to an internal node, or the pin reference with an internal one, is a short.
  assign short_o = ((|ain_i) & int_i) | (ref_pin_i & ref_int_i);
endmodule

/* tb/arsel_top_bench.sv */
/*
  Self-checking bench for the reference and input select block.
  Assumes the Avalon-MM timing and register map of the block's package.
*/
`timescale 1ns/10ps
module arsel_top_bench;
  import arsel_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [31:0] bus_d;
  logic [1:0] bus_r;
  logic waitreq;
  logic [8:0] ctl_o;
  logic [13:0] in_o;
  logic [8:0] ain;
  logic [8:0] pfd, ppu, pdir;
  logic short;
  logic [7:0] r, b, sc;
  logic [8:0] p;
  int seed, num_errors, num_checks;
  // ==========================================================================
  // Design and far-side model
  arsel_top u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .AVS_RESPONSE_O(rresp),
    .AMP_ENABLE_O(ctl_o[8]), .AMP_SRC_BANDGAP_O(ctl_o[7]), .AMP_REF_PIN_CONNECT_O(ctl_o[6]),
    .AMP_GAIN_SEL_O(ctl_o[5:4]), .BANDGAP_ENABLE_O(ctl_o[3]), .REF_SEL_SUPPLY_O(ctl_o[2]),
    .REF_SEL_PIN_O(ctl_o[1]), .REF_SEL_AMP_O(ctl_o[0]), .AIN_CONNECT_O(ain),
    .INT_SUPPLY_O(in_o[4]), .INT_AMP_O(in_o[3]), .INT_GND_O(in_o[2]), .INT_DIV_O(in_o[1:0]),
    .PIN_FUNC_DISABLE_O(pfd), .PIN_PULLUP_OFF_O(ppu), .PIN_DIR_FORCE_IN_O(pdir));
  assign in_o[13:5] = ain;
  arsel_analog_model u_model (.ain_i(ain), .int_i(|in_o[4:2]), .ref_pin_i(ctl_o[1]),
    .ref_int_i(ctl_o[2] | ctl_o[0]), .short_o(short));
  // Clock of 5 ns period.
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================================================
  // Expectations
  function automatic logic [8:0] f_ctl(logic [7:0] rv, logic [7:0] bv);
    f_ctl = {rv[7], rv[4], !rv[4], rv[1:0], bv[0], rv[3:2] == 2'h0, rv[3:2] == 2'h1, rv[3]};
  endfunction
  function automatic logic [13:0] f_in(logic [3:0] s, logic [3:0] c, logic [8:0] pv);
    logic ext;
    logic [8:0] oh;
    ext = (s == 4'h0) | (s == 4'h4) | (s[3:2] == 2'h3);
    oh = (c <= 4'h8 && c != 4'h2) ? (9'h001 << c) : 9'h000;
    f_in = {ext ? (oh & pv) : 9'h000, s[3:2] == 2'h0 && s[1:0] != 2'h0,
      s[3:2] == 2'h1 && s[1:0] != 2'h0, s[3:2] == 2'h2, s[3] ? 2'h0 : s[1:0]};
  endfunction
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk(1, 0, "bus hang");
    bus_d = rdata;
    bus_r = rresp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compares every select output against the register contents.
  task automatic chk_outs;
    #1;
    chk(ctl_o, f_ctl(r, b), "amp/ref selects");
    chk(in_o, f_in(sc[7:4], sc[3:0], p), "input selects");
    chk({pfd, ppu, pdir}, {p, p, p}, "pin overrides");
    chk(short, 1'b0, "analog short");
  endtask
  // ==========================================================================
  // Watchdog on a 20000-cycle budget.
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    seed = 32'haa126e86;
    {r, b, sc, p} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    chk_outs;
    bus(1'b0, OFS_REF_AMP_CTRL, 32'h0);
    chk(bus_d, 32'h0, "ref reset");
    bus(1'b0, 4'h6, 32'h0);
    chk({bus_r, bus_d}, {2'h2, 32'h0}, "unmapped read");
    // A write without byte lane 0 must leave the register alone.
    be <= 4'h0;
    bus(1'b1, OFS_REF_AMP_CTRL, 32'hFF);
    be <= 4'hF;
    bus(1'b0, OFS_REF_AMP_CTRL, 32'h0);
    chk(bus_d, 32'h0, "write without lane 0");
    for (int i = 0; i < 256; i++) begin
      sc = i[7:0];
      p = 9'($random(seed));
      r = 8'($random(seed));
      b = 8'($random(seed));
      if (i == 255) r = 8'hFF;
      r[7] = r[3] | (sc[7:6] == 2'h1 && sc[5:4] != 2'h0);
      if (r[4]) b[0] = 1'b1;
      bus(1'b1, OFS_BANDGAP_CTRL, {24'hFFFFFF, b});
      bus(1'b1, OFS_INPUT_SEL, {24'h0, sc});
      bus(1'b1, OFS_PIN_ANALOG, {23'h0, p});
      bus(1'b1, OFS_REF_AMP_CTRL, {24'h0, r});
      chk_outs;
      bus(1'b0, OFS_REF_AMP_CTRL, 32'h0);
      chk(bus_d, {24'h0, r & 8'h9F}, "ref readback");
      bus(1'b0, OFS_BANDGAP_CTRL, 32'h0);
      chk({bus_r, bus_d}, {2'h0, 31'h0, b[0]}, "bandgap readback");
    end
    // Reset in mid-run: every output must fall back to its reset state.
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    {r, b, sc, p} = '0;
    chk_outs;
    bus(1'b0, OFS_INPUT_SEL, 32'h0);
    chk(bus_d, 32'h0, "input reset");
    report_and_stop;
  end
endmodule
